/* File: hw/tim_cfg.svh */
`ifndef TIM_CFG_SVH
`define TIM_CFG_SVH
// Channel count and masks
`define NCH         6
`define CH_MASK     6'h3f
`define ACC_MASK    2'h3
// Register word indices; byte address is four times the index
`define IX_SELECT   6'h00
`define IX_FORCE    6'h01
`define IX_COUNT    6'h04
`define IX_CTRL     6'h06
`define IX_TOGGLE   6'h07
`define IX_ACTION   6'h08
`define IX_IRQEN    6'h0c
`define IX_FLAGS    6'h0e
`define IX_OVF      6'h0f
`define IX_VALUE0   6'h10
`define IX_VALUE5   6'h15
`define IX_PORT     6'h18
`define IX_DIR      6'h19
`define IX_ACCFLG   6'h21
`define IX_ACCHI    6'h22
`define IX_ACCLO    6'h23
`define IX_DISC     6'h2c
`define IX_PRESC    6'h2e
// Bit positions
`define BIT_TEN     7
`define BIT_OVFIE   0
`define BIT_OVF     7
// Reset values and counter limits
`define RST_BYTE    8'h00
`define RST_CH      6'h00
`define RST_WORD    16'h0000
`define RST_ACT     12'h000
`define CNT_MAX     16'hffff
// Output action codes, mode bit upper
`define ACT_NONE    2'b00
`define ACT_TOGGLE  2'b01
`define ACT_CLEAR   2'b10
`define ACT_SET     2'b11
`endif

/* File: hw/tim_pkg.sv */
package tim_pkg;
  typedef logic [5:0]  chan_type;
  typedef logic [15:0] count_type;
  typedef logic [31:0] word_type;
  typedef logic [7:0]  byte_type;
  typedef logic [7:0]  addr_type;
endpackage

/* File: hw/timer_capture_compare_channels.sv */
`timescale 1ns/100ps
`include "tim_cfg.svh"

module timer_capture_compare_channels (
  input  wire logic          CLK_I,
  input  wire logic          RSTN_I,
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire tim_pkg::addr_type PADDR_I,
  input  wire tim_pkg::word_type PWDATA_I,
  output tim_pkg::word_type  PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  input  wire tim_pkg::chan_type CHAN_PIN_I,
  output tim_pkg::chan_type  CHAN_PIN_O,
  output tim_pkg::chan_type  CHAN_PIN_OE_O,
  output tim_pkg::chan_type  CHAN_IRQ_O,
  output logic               OVF_IRQ_O
);
  import tim_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  chan_type  sel_reg;        // Capture/compare select
  byte_type  ctrl_reg;       // Timer enable, overflow irq enable
  chan_type  tov_reg;        // Toggle at wrap
  logic [11:0] act_reg;      // Mode/level pairs
  chan_type  ie_reg;         // Channel irq enable
  chan_type  flag_reg;       // Channel event flags
  chan_type  flag_next;
  logic      ovf_reg;        // Counter overflow flag
  logic      ovf_next;
  count_type cnt_reg;        // Timer counter
  count_type val_reg [`NCH]; // Channel values
  chan_type  port_reg;       // General-purpose port data
  chan_type  dir_reg;        // General-purpose direction
  logic [1:0] accflg_reg;    // Accumulator flags
  count_type acc_reg;        // Accumulator count
  chan_type  disc_reg;       // Output disconnect
  byte_type  presc_reg;      // Prescaler value
  byte_type  pre_cnt_reg;    // Prescaler divider
  chan_type  oc_reg;         // Compare output latches
  chan_type  oc_next;
  chan_type  pin_d1_reg;     // Pin sample, one cycle back
  chan_type  pin_d2_reg;     // Pin sample, two cycles back
  word_type  prdata_reg;
  logic      pready_reg;
  logic      slverr_reg;
  chan_type  pin_o_reg;
  chan_type  pin_oe_reg;
  chan_type  irq_reg;
  logic      ovf_irq_reg;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic      setup;          // Setup phase of a transfer
  logic      wr_en;          // Write taking effect now
  logic [5:0] idx;           // Word index
  logic [2:0] vix;           // Value register index
  logic      aligned;
  word_type  rdata;
  logic      hit;
  assign setup   = PSEL_I & ~PENABLE_I;
  assign wr_en   = PSEL_I & PENABLE_I & PWRITE_I & pready_reg & aligned;
  assign idx     = PADDR_I[7:2];
  assign aligned = (PADDR_I[1:0] == 2'b00);
  assign vix     = 3'(idx - `IX_VALUE0);
  // ----------------------------------------
  // Counter and prescaler
  // ----------------------------------------
  logic      timer_enable_bit;            // Timer enable
  logic      tick;           // Counter advance
  logic      wrap;           // Counter passes maximum
  count_type cnt_inc;
  assign timer_enable_bit     = ctrl_reg[`BIT_TEN];
  assign tick    = timer_enable_bit & (pre_cnt_reg == presc_reg);
  assign cnt_inc = cnt_reg + 16'h0001;
  assign wrap    = tick & (cnt_reg == `CNT_MAX);
  // Prescaler divides by value plus one
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pre_cnt_reg <= `RST_BYTE;
    end else if (!timer_enable_bit || tick) begin
      pre_cnt_reg <= `RST_BYTE;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 8'h01;
    end
  end
  // Free-running up counter, wraps to zero
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      cnt_reg <= `RST_WORD;
    end else if (wr_en && idx == `IX_COUNT) begin
      cnt_reg <= PWDATA_I[15:0];
    end else if (tick) begin
      cnt_reg <= cnt_inc;
    end
  end
  // ----------------------------------------
  // Channel events
  // ----------------------------------------
  chan_type cap_ev;          // Capture events
  chan_type match;           // Compare matches
  chan_type force_w;         // Forced compares
  chan_type clr;             // Flag clear mask
  chan_type drv;             // Compare owns pin
  // Edge needs the pin high on two samples
  assign cap_ev  = ~sel_reg & CHAN_PIN_I & pin_d1_reg & ~pin_d2_reg;
  assign force_w = (wr_en && idx == `IX_FORCE) ? (PWDATA_I[5:0] & sel_reg) : `RST_CH;
  assign clr     = (wr_en && idx == `IX_FLAGS) ? PWDATA_I[5:0] : `RST_CH;
  // Per-channel compare and pin ownership
  for (genvar c = 0; c < `NCH; c++) begin : g_ch
    assign match[c] = tick & sel_reg[c] & (cnt_inc == val_reg[c]);
    assign drv[c]   = sel_reg[c] & (act_reg[2*c+:2] != `ACT_NONE)
                      & ~disc_reg[c];
  end
  // Pin history for edge detection
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pin_d1_reg <= `RST_CH;
      pin_d2_reg <= `RST_CH;
    end else begin
      pin_d1_reg <= CHAN_PIN_I;
      pin_d2_reg <= pin_d1_reg;
    end
  end
  // Channel values: capture wins over a bus write
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      for (int c = 0; c < `NCH; c++) begin
        val_reg[c] <= `RST_WORD;
      end
    end else begin
      for (int c = 0; c < `NCH; c++) begin
        if (cap_ev[c]) begin
          val_reg[c] <= cnt_reg;
        end else if (wr_en && idx == `IX_VALUE0 + 6'(c)) begin
          val_reg[c] <= PWDATA_I[15:0];
        end
      end
    end
  end
  // ----------------------------------------
  // Compare output latches
  // ----------------------------------------
  always_comb begin
    oc_next = oc_reg;
    for (int c = 0; c < `NCH; c++) begin
      if (wrap && tov_reg[c] && sel_reg[c]) begin
        oc_next[c] = ~oc_reg[c];
      end else if (match[c] || force_w[c]) begin
        case (act_reg[2*c+:2])
          `ACT_TOGGLE: oc_next[c] = ~oc_reg[c];
          `ACT_CLEAR:  oc_next[c] = 1'b0;
          `ACT_SET:    oc_next[c] = 1'b1;
          default:     oc_next[c] = oc_reg[c];
        endcase
      end
    end
  end
  // Latches preset even while disconnected
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      oc_reg <= `RST_CH;
    end else begin
      oc_reg <= oc_next;
    end
  end
  // Pin drive: compare output or latched port data
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pin_o_reg  <= `RST_CH;
      pin_oe_reg <= `RST_CH;
    end else begin
      for (int c = 0; c < `NCH; c++) begin
        if (drv[c]) begin
          pin_o_reg[c] <= oc_next[c];
        end else begin
          pin_o_reg[c] <= port_reg[c];
        end
      end
      pin_oe_reg <= drv | dir_reg;
    end
  end
  // ----------------------------------------
  // Flags and interrupt lines
  // ----------------------------------------
  // Set wins over a same-cycle clear
  assign flag_next = (flag_reg & ~clr) | cap_ev | match;
  assign ovf_next  = (ovf_reg & ~(wr_en && idx == `IX_OVF && PWDATA_I[`BIT_OVF])) | wrap;
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      flag_reg    <= `RST_CH;
      ovf_reg     <= 1'b0;
      irq_reg     <= `RST_CH;
      ovf_irq_reg <= 1'b0;
    end else begin
      flag_reg    <= flag_next;
      ovf_reg     <= ovf_next;
      irq_reg     <= flag_next & ie_reg;
      ovf_irq_reg <= ovf_next & ctrl_reg[`BIT_OVFIE];
    end
  end
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sel_reg    <= `RST_CH;
      ctrl_reg   <= `RST_BYTE;
      tov_reg    <= `RST_CH;
      act_reg    <= `RST_ACT;
      ie_reg     <= `RST_CH;
      port_reg   <= `RST_CH;
      dir_reg    <= `RST_CH;
      disc_reg   <= `RST_CH;
      presc_reg  <= `RST_BYTE;
      accflg_reg <= 2'b00;
      acc_reg    <= `RST_WORD;
    end else if (wr_en) begin
      if (idx == `IX_SELECT) begin
        sel_reg <= PWDATA_I[5:0] & `CH_MASK;
      end else if (idx == `IX_CTRL) begin
        ctrl_reg <= PWDATA_I[7:0];
      end else if (idx == `IX_TOGGLE) begin
        tov_reg <= PWDATA_I[5:0];
      end else if (idx == `IX_ACTION) begin
        act_reg <= PWDATA_I[11:0];
      end else if (idx == `IX_IRQEN) begin
        ie_reg <= PWDATA_I[5:0];
      end else if (idx == `IX_PORT) begin
        port_reg <= PWDATA_I[5:0];
      end else if (idx == `IX_DIR) begin
        dir_reg <= PWDATA_I[5:0];
      end else if (idx == `IX_DISC) begin
        disc_reg <= PWDATA_I[5:0];
      end else if (idx == `IX_PRESC) begin
        presc_reg <= PWDATA_I[7:0];
      end else if (idx == `IX_ACCFLG) begin
        accflg_reg <= accflg_reg & ~PWDATA_I[1:0];
      end else if (idx == `IX_ACCHI) begin
        acc_reg[15:8] <= PWDATA_I[7:0];
      end else if (idx == `IX_ACCLO) begin
        acc_reg[7:0] <= PWDATA_I[7:0];
      end
    end
  end
  // Read mux; unmapped index flags an error
  always_comb begin
    rdata = '0;
    hit   = aligned;
    if (idx == `IX_SELECT) begin
      rdata[5:0] = sel_reg;
    end else if (idx == `IX_FORCE) begin
      rdata = '0;
    end else if (idx == `IX_COUNT) begin
      rdata[15:0] = cnt_reg;
    end else if (idx == `IX_CTRL) begin
      rdata[7:0] = ctrl_reg;
    end else if (idx == `IX_TOGGLE) begin
      rdata[5:0] = tov_reg;
    end else if (idx == `IX_ACTION) begin
      rdata[11:0] = act_reg;
    end else if (idx == `IX_IRQEN) begin
      rdata[5:0] = ie_reg;
    end else if (idx == `IX_FLAGS) begin
      rdata[5:0] = flag_reg;
    end else if (idx == `IX_OVF) begin
      rdata[`BIT_OVF] = ovf_reg;
    end else if (idx >= `IX_VALUE0 && idx <= `IX_VALUE5) begin
      rdata[15:0] = val_reg[vix];
    end else if (idx == `IX_PORT) begin
      rdata[5:0] = port_reg;
    end else if (idx == `IX_DIR) begin
      rdata[5:0] = dir_reg;
    end else if (idx == `IX_ACCFLG) begin
      rdata[1:0] = accflg_reg & `ACC_MASK;
    end else if (idx == `IX_ACCHI) begin
      rdata[7:0] = acc_reg[15:8];
    end else if (idx == `IX_ACCLO) begin
      rdata[7:0] = acc_reg[7:0];
    end else if (idx == `IX_DISC) begin
      rdata[5:0] = disc_reg;
    end else if (idx == `IX_PRESC) begin
      rdata[7:0] = presc_reg;
    end else begin
      hit = 1'b0;
    end
  end
  // Answer one cycle after setup, no wait states
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pready_reg <= 1'b0;
      prdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      slverr_reg <= setup & ~hit;
      if (setup && !PWRITE_I) begin
        prdata_reg <= rdata;
      end
    end
  end
  assign PRDATA_O      = prdata_reg;
  assign PREADY_O      = pready_reg;
  assign PSLVERR_O     = slverr_reg;
  assign CHAN_PIN_O    = pin_o_reg;
  assign CHAN_PIN_OE_O = pin_oe_reg;
  assign CHAN_IRQ_O    = irq_reg;
  assign OVF_IRQ_O     = ovf_irq_reg;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_capture_value: assert property (cap_ev[0] |=> val_reg[0] == $past(cnt_reg))
    else $error("capture value wrong");
  a_capture_flag: assert property (cap_ev[0] |=> flag_reg[0]) else $error("capture flag not set");
  a_match_flag: assert property (match[2] |=> flag_reg[2]) else $error("match flag not set");
  a_irq_line: assert property ($rose(flag_reg[0]) && $past(ie_reg[0]) |-> CHAN_IRQ_O[0])
    else $error("channel request missing");
  a_force_noflag: assert property (force_w != 0 && match == 0 && cap_ev == 0
    |=> flag_reg == $past(flag_reg))
    else $error("force changed flags");
  a_clear_action: assert property ((match[1] || force_w[1]) && act_reg[3:2] == `ACT_CLEAR
    && !(wrap && tov_reg[1]) |=> !oc_reg[1])
    else $error("clear action failed");
  a_wrap_toggle: assert property (wrap && tov_reg[2] && sel_reg[2]
    |=> oc_reg[2] != $past(oc_reg[2]))
    else $error("wrap toggle missed");
  a_counter_wrap: assert property (wrap && !(wr_en && idx == `IX_COUNT)
    |=> cnt_reg == `RST_WORD && ovf_reg && OVF_IRQ_O == $past(ctrl_reg[`BIT_OVFIE]))
    else $error("counter wrap wrong");
  a_pin_drive: assert property (drv[1] |=> CHAN_PIN_OE_O[1] && CHAN_PIN_O[1] == oc_reg[1])
    else $error("compare not driving pin");
  a_port_hold: assert property (drv[2] && $stable(drv[2]) |-> CHAN_PIN_O[2] == oc_reg[2])
    else $error("port data reached pin");
  a_select_read: assert property (setup && !PWRITE_I && idx == `IX_SELECT
    |=> PRDATA_O[31:6] == 26'h0)
    else $error("select upper bits nonzero");
  c_capture: cover property (cap_ev[0] ##1 CHAN_IRQ_O[0]);
  c_compare: cover property (match[2] && drv[2]);
  c_wrap:    cover property (wrap ##1 OVF_IRQ_O);
endmodule

/* File: test/pin_partner.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Pin-side partner: event sources and loads
// ----------------------------------------
module pin_partner (
  input  wire logic             clk_i,
  input  wire tim_pkg::chan_type pin_o_i,
  input  wire tim_pkg::chan_type pin_oe_i,
  output tim_pkg::chan_type     lvl_o
);
  import tim_pkg::*;
  chan_type src_reg;  // Level driven by the external source

  initial begin
    src_reg = '0;
  end

  // Driven pins follow the block; released pins show the source
  assign lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & src_reg);

  // Pulse held for len cycles; callers keep len above two
  task automatic pulse(input int ch, input int len);
    src_reg[ch] <= 1'b1;
    repeat (len) @(posedge clk_i);
    src_reg[ch] <= 1'b0;
  endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
`include "tim_cfg.svh"
// ----------------------------------------
// Register-level bench over APB
// ----------------------------------------
module testbench;
  import tim_pkg::*;
  logic     clk = 1'b0;       // 250 MHz clock
  logic     rstn = 1'b0;      // Synchronous reset, active low
  logic     psel = 1'b0;      // APB select
  logic     pen = 1'b0;       // APB enable
  logic     pwr = 1'b0;       // APB direction
  addr_type paddr = '0;       // APB byte address
  word_type pwdata = '0;      // APB write data
  word_type prdata;           // APB read data
  word_type rd;               // Last read word
  logic     pready;           // APB ready
  logic     pslverr;          // APB error
  logic     er;               // Last error flag
  chan_type pin_i;            // Resolved pin levels
  chan_type pin_o;            // Pin values
  chan_type pin_oe;           // Pin enables
  chan_type irq;              // Channel requests
  logic     ovf;              // Overflow request
  count_type a;               // Counter snapshot
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [1:0] codes [3] = '{`ACT_SET, `ACT_CLEAR, `ACT_TOGGLE};
  logic [2:0] lvl = 3'b101;   // Pin level after each forced code

  initial begin
    forever #2 clk = ~clk;
  end

  timer_capture_compare_channels DUT (
    .CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CHAN_PIN_I(pin_i), .CHAN_PIN_O(pin_o),
    .CHAN_PIN_OE_O(pin_oe), .CHAN_IRQ_O(irq), .OVF_IRQ_O(ovf));

  pin_partner part (.clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .lvl_o(pin_i));

  // Compare one value and count it
  task automatic check(input string nm, input word_type seen, input word_type exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer: setup, then access held until ready
  task automatic apb(input logic wr, input logic [5:0] ix, input word_type wd);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= {ix, 2'b00}; pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // Ready ends this wait; the hang guard ends a stuck one
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] ix, input word_type d);
    apb(1'b1, ix, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Counts, verdict and end of run
  task automatic finish_test;
    $display("TB: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    tick(16);
    rstn <= 1'b1;
    apb(0, `IX_ACTION, 0); check("action", rd, 0);
    apb(0, `IX_DISC, 0); check("disc", rd, 0);
    apb(0, 6'h3f, 0); check("unmapped", {31'h0, er}, 1);
    wr(`IX_SELECT, 32'hff); apb(0, `IX_SELECT, 0); check("select", rd, 32'h3f);
    $display("test registers done");
    wr(`IX_SELECT, 0); wr(`IX_CTRL, 32'h80); wr(`IX_IRQEN, 1);
    apb(0, `IX_COUNT, 0); a = rd[15:0];
    part.pulse(0, 4); tick(3);
    apb(0, `IX_VALUE0, 0); check("capture", {31'h0, rd[15:0] >= a && rd[15:0] <= a + 16'd60}, 1);
    apb(0, `IX_FLAGS, 0); check("cap flag", rd[0], 1);
    check("cap irq", irq[0], 1);
    wr(`IX_FLAGS, 1); tick(2); apb(0, `IX_FLAGS, 0); check("clear", rd, 0);
    check("irq off", irq[0], 0);
    $display("test capture done");
    wr(`IX_SELECT, 32'h3e);
    for (int i = 0; i < 3; i++) begin
      wr(`IX_ACTION, 32'(codes[i]) << 2); wr(`IX_FORCE, 2); tick(2);
      check("force pin", pin_o[1], lvl[i]);
      check("force oe", pin_oe[1], 1);
    end
    apb(0, `IX_FLAGS, 0); check("force flag", rd, 0);
    wr(`IX_DISC, 2); wr(`IX_ACTION, 32'(`ACT_CLEAR) << 2); wr(`IX_FORCE, 2); tick(2);
    check("disc oe", pin_oe[1], 0);
    wr(`IX_DISC, 0); tick(2); check("handover", {pin_oe[1], pin_o[1]}, 2'b10);
    wr(`IX_DIR, 2); wr(`IX_PORT, 2); tick(2); check("latch", pin_o[1], 0);
    wr(`IX_ACTION, 0); tick(2); check("gpio", {pin_oe[1], pin_o[1]}, 2'b11);
    $display("test force done");
    wr(`IX_IRQEN, 32'hc); apb(0, `IX_COUNT, 0); a = rd[15:0] + 16'd60;
    wr(`IX_VALUE0 + 6'h2, a); wr(`IX_VALUE0 + 6'h3, a);
    wr(`IX_ACTION, 32'(`ACT_TOGGLE) << 4);
    for (int i = 0; i < 40; i++) begin
      apb(0, `IX_FLAGS, 0);
      if (rd[2] === 1'b1) break;
    end
    tick(2);
    check("match flag", rd[3:2], 2'b11);
    check("match pin", pin_o[2], 1);
    check("match oe", pin_oe[3:2], 2'b01);
    check("match irq", irq[3:2], 2'b11);
    $display("test compare done");
    // Counter preset near its top so that it wraps within the run
    wr(`IX_CTRL, 32'h81); wr(`IX_TOGGLE, 32'h4); wr(`IX_COUNT, 32'hffc0); tick(80);
    check("ovf irq", ovf, 1);
    apb(0, `IX_OVF, 0); check("ovf flag", rd, 32'h80);
    check("wrap pin", pin_o[2], 0);
    wr(`IX_OVF, 32'h80); tick(2); check("ovf clear", ovf, 0);
    apb(0, `IX_COUNT, 0); check("wrapped", {31'h0, rd[15:0] < 16'h0100}, 1);
    $display("test overflow done");
    finish_test();
  end
endmodule
